// ### rtl/rscr_defs.vh
// Register offsets, field positions, reset values and timing counts
`ifndef RSCR_DEFS_VH
`define RSCR_DEFS_VH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define RSCR_ADDR_POST_FILTER 7'h03
`define RSCR_ADDR_WORD_HIGH 7'h09
`define RSCR_ADDR_WORD_MID 7'h0A
`define RSCR_ADDR_WORD_LOW 7'h0B
`define RSCR_ADDR_AFE_CTL 7'h19
`define RSCR_ADDR_RECOVERY 7'h35

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define RSCR_PF_FINE_LSB 0
`define RSCR_PF_COARSE_LSB 3
`define RSCR_PF_BW_BIT 6
`define RSCR_PF_BUF_BIT 7
`define RSCR_AFE_XDIV_LSB 0
`define RSCR_AFE_LO_OUTPUT_DIVIDER_LSB 4
`define RSCR_AFE_INJ_BIT 3
`define RSCR_AFE_FRAC_BIT 2
`define RSCR_REC_MODE_LSB 0

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RSCR_RST_POST_FILTER 8'h00
`define RSCR_RST_WORD 8'h00
`define RSCR_RST_AFE_CTL 8'h05
`define RSCR_RST_RECOVERY 8'h00

// ------------------------------------------------------------
// Timing and ratios
// ------------------------------------------------------------
`define RSCR_XDIV_RATIO_BASE 3'h4
`define RSCR_SYNTH_STEP_DIV 65536
`define RSCR_SYNTH_STEP_BITS 16
`define RSCR_BAUD_DIV_DEF 16'h0064
`define RSCR_MODE_OFF 2'h0
`define RSCR_MODE_CLK 2'h1
`define RSCR_MODE_RETIME 2'h2
`define RSCR_MODE_BOTH 2'h3
`define RSCR_LAT_DEFAULT 2'h0
`define RSCR_LAT_LOWER 2'h1
`define RSCR_LAT_LOWEST 2'h2

`endif

// ### rtl/rscr_buf2.v
// Two-entry valid/ready buffer for recovered data bits
`timescale 1ns/10ps
`default_nettype none
module rscr_buf2 #(
    parameter WIDTH = 1
) (
    input wire clk,
    input wire rst_b,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_reg [0:1];
    reg wptr_reg;
    reg rptr_reg;
    reg [1:0] cnt_reg;
    wire push;
    wire pop;

    assign in_ready = (cnt_reg != 2'h2);
    assign out_valid = (cnt_reg != 2'h0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_reg[rptr_reg];

    always @(posedge clk) begin
        if (push) begin
            mem_reg[wptr_reg] <= in_data;
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wptr_reg <= 1'b0;
            rptr_reg <= 1'b0;
            cnt_reg <= 2'h0;
        end else begin
            if (push) begin
                wptr_reg <= ~wptr_reg;
            end
            if (pop) begin
                rptr_reg <= ~rptr_reg;
            end
            if (push && !pop) begin
                cnt_reg <= cnt_reg + 2'h1;
            end else if (pop && !push) begin
                cnt_reg <= cnt_reg - 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ### rtl/rscr_top.v
// Receiver synthesizer configuration, time base and clock recovery
// Function
// (RULE1) Host picks crystal divider select code
// (RULE2) Divide crystal clock to 3.2 MHz base
// (RULE3) Synth step is crystal over 65536
// (RULE4) 24-bit synth word in three bytes
// (RULE5) Host computes word with IF offset
// (RULE6) Host uses FSK mark/space midpoint
// (RULE7) Host sets LO divider per band
// (RULE8) Host always sets fractional enable
// (RULE9) Clock only when programmable, decimation nonzero
// (RULE10) Mode field selects clock and retiming
// (RULE11) Clock twice data rate, rise mid-bit
// (RULE12) Host latches data on rising clock
// (RULE13) Injection bit selects low or high side
// (RULE14) Host keeps low-side except calibration
// (RULE15) Latency bits select filter delay path
// (RULE16) Host avoids reserved latency combination; the bench writes it once to check LATENCY_RESERVED
// (RULE17) Host sets buffer only with valid decimation
// (RULE18) NRZ ASK threshold settings, 16-bit runs
// (RULE19) NRZ FSK gain zero, short runs
// (RULE20) Host uses three-wire serial registers; the code has a parallel REG_WE/REG_ADDR/REG_WDATA port instead
// (RULE21) Align phase to data, clock low off
`timescale 1ns/10ps
`default_nettype none
`include "rscr_defs.vh"
module rscr_top #(
    parameter BAUD_DIV = `RSCR_BAUD_DIV_DEF
) (
    input wire MCLK,
    input wire RST_B,
    input wire REG_WE,
    input wire [6:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    output reg [7:0] REG_RDATA,
    input wire PROG_MODE,
    input wire DEMOD_IN,
    output reg DATA_OUT,
    output reg CLK_OUT,
    input wire HOST_READY,
    output wire BIT_VALID,
    output wire BIT_DATA,
    output wire TIMEBASE_TICK,
    output wire [23:0] SYNTH_WORD,
    output wire [15:0] SYNTH_INT,
    output wire [15:0] SYNTH_FRAC,
    output wire [1:0] LO_DIVIDER,
    output wire FRAC_ENABLE,
    output wire INJECT_HIGH,
    output wire [1:0] LATENCY_SEL,
    output wire LATENCY_RESERVED
);
    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    reg [7:0] post_filter_config_reg;
    reg [7:0] synth_word_high_reg;
    reg [7:0] synth_word_mid_reg;
    reg [7:0] synth_word_low_reg;
    reg [7:0] analog_frontend_control_reg;
    reg [7:0] recovery_config_reg;

    always @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            post_filter_config_reg <= `RSCR_RST_POST_FILTER;
            synth_word_high_reg <= `RSCR_RST_WORD;
            synth_word_mid_reg <= `RSCR_RST_WORD;
            synth_word_low_reg <= `RSCR_RST_WORD;
            analog_frontend_control_reg <= `RSCR_RST_AFE_CTL;
            recovery_config_reg <= `RSCR_RST_RECOVERY;
        end else if (REG_WE) begin
            case (REG_ADDR)
                `RSCR_ADDR_POST_FILTER: begin
                    post_filter_config_reg <= REG_WDATA;
                end
                // (RULE4) Synth word bytes
                `RSCR_ADDR_WORD_HIGH: begin
                    synth_word_high_reg <= REG_WDATA;
                end
                `RSCR_ADDR_WORD_MID: begin
                    synth_word_mid_reg <= REG_WDATA;
                end
                `RSCR_ADDR_WORD_LOW: begin
                    synth_word_low_reg <= REG_WDATA;
                end
                `RSCR_ADDR_AFE_CTL: begin
                    analog_frontend_control_reg <= REG_WDATA;
                end
                `RSCR_ADDR_RECOVERY: begin
                    recovery_config_reg <= {6'h00, REG_WDATA[1:0]};
                end
                default: begin
                end
            endcase
        end
    end

    always @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            REG_RDATA <= 8'h00;
        end else begin
            case (REG_ADDR)
                `RSCR_ADDR_POST_FILTER: REG_RDATA <= post_filter_config_reg;
                `RSCR_ADDR_WORD_HIGH: REG_RDATA <= synth_word_high_reg;
                `RSCR_ADDR_WORD_MID: REG_RDATA <= synth_word_mid_reg;
                `RSCR_ADDR_WORD_LOW: REG_RDATA <= synth_word_low_reg;
                `RSCR_ADDR_AFE_CTL: REG_RDATA <= analog_frontend_control_reg;
                `RSCR_ADDR_RECOVERY: REG_RDATA <= recovery_config_reg;
                default: REG_RDATA <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    wire [1:0] xtal_clock_divider_sel;
    wire [1:0] lo_output_divider;
    wire fractional_synth_enable;
    wire injection_side_select;
    wire [2:0] coarse_rate_decimation;
    wire [2:0] fine_rate_decimation;
    wire latency_bandwidth_boost;
    wire latency_bypass_buffer;
    wire [1:0] recovery_output_mode;

    assign xtal_clock_divider_sel =
        analog_frontend_control_reg[`RSCR_AFE_XDIV_LSB +: 2];
    assign lo_output_divider =
        analog_frontend_control_reg[`RSCR_AFE_LO_OUTPUT_DIVIDER_LSB +: 2];
    assign fractional_synth_enable =
        analog_frontend_control_reg[`RSCR_AFE_FRAC_BIT];
    assign injection_side_select =
        analog_frontend_control_reg[`RSCR_AFE_INJ_BIT];
    assign coarse_rate_decimation =
        post_filter_config_reg[`RSCR_PF_COARSE_LSB +: 3];
    assign fine_rate_decimation =
        post_filter_config_reg[`RSCR_PF_FINE_LSB +: 3];
    assign latency_bandwidth_boost = post_filter_config_reg[`RSCR_PF_BW_BIT];
    assign latency_bypass_buffer = post_filter_config_reg[`RSCR_PF_BUF_BIT];
    assign recovery_output_mode =
        recovery_config_reg[`RSCR_REC_MODE_LSB +: 2];

    // ------------------------------------------------------------
    // Synthesizer settings
    // ------------------------------------------------------------
    // (RULE4) Word assembly
    assign SYNTH_WORD = {synth_word_high_reg, synth_word_mid_reg,
                         synth_word_low_reg};
    // (RULE3) Crystal over 65536 step
    assign SYNTH_INT = {8'h00, SYNTH_WORD[23:`RSCR_SYNTH_STEP_BITS]};
    assign SYNTH_FRAC = SYNTH_WORD[`RSCR_SYNTH_STEP_BITS-1:0];
    assign LO_DIVIDER = lo_output_divider;
    assign FRAC_ENABLE = fractional_synth_enable;
    // (RULE13) Injection side select
    assign INJECT_HIGH = injection_side_select;

    // (RULE15) Latency path select
    assign LATENCY_SEL = !latency_bandwidth_boost ? `RSCR_LAT_DEFAULT :
                         (latency_bypass_buffer ? `RSCR_LAT_LOWEST :
                          `RSCR_LAT_LOWER);
    assign LATENCY_RESERVED = !latency_bandwidth_boost &&
                              latency_bypass_buffer;

    // ------------------------------------------------------------
    // Crystal divider time base
    // ------------------------------------------------------------
    reg [2:0] xdiv_cnt_reg;
    reg tick_reg;
    wire [2:0] xdiv_ratio;

    // Code 3 is not defined; it falls back to ratio 6
    // (RULE2) Ratio 4, 5 or 6
    assign xdiv_ratio = `RSCR_XDIV_RATIO_BASE +
                        {1'b0, (xtal_clock_divider_sel == 2'h3) ?
                         2'h2 : xtal_clock_divider_sel};

    always @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            xdiv_cnt_reg <= 3'h0;
            tick_reg <= 1'b0;
        end else if (xdiv_cnt_reg >= xdiv_ratio - 3'h1) begin
            xdiv_cnt_reg <= 3'h0;
            tick_reg <= 1'b1;
        end else begin
            xdiv_cnt_reg <= xdiv_cnt_reg + 3'h1;
            tick_reg <= 1'b0;
        end
    end
    assign TIMEBASE_TICK = tick_reg;

    // ------------------------------------------------------------
    // Clock data recovery
    // ------------------------------------------------------------
    reg [15:0] phase_reg;
    reg demod_d_reg;
    reg bit_reg;
    reg sample_reg;
    wire clk_allowed;
    wire clk_on;
    wire retime_on;
    wire edge_seen;
    wire demod_edge;
    reg edge_pend_reg;
    wire [15:0] half_bit;
    wire [15:0] quarter_bit;

    // (RULE9) Clock availability
    assign clk_allowed = PROG_MODE &&
        ((coarse_rate_decimation != 3'h0) || (fine_rate_decimation != 3'h0));
    // (RULE10) Mode decode
    assign clk_on = clk_allowed && recovery_output_mode[0];
    assign retime_on = clk_allowed && recovery_output_mode[1];
    assign demod_edge = DEMOD_IN ^ demod_d_reg;
    assign edge_seen = demod_edge || edge_pend_reg;
    assign half_bit = {1'b0, BAUD_DIV[15:1]};
    assign quarter_bit = {2'h0, BAUD_DIV[15:2]};

    // ------------------------------------------------------------
    // Edge capture between ticks
    // ------------------------------------------------------------
    // A data edge that falls between two ticks would otherwise be lost,
    // so it is held until the tick that consumes it.
    // (RULE21) Hold edge until next tick
    always @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            edge_pend_reg <= 1'b0;
        end else if (tick_reg) begin
            edge_pend_reg <= 1'b0;
        end else if (demod_edge) begin
            edge_pend_reg <= 1'b1;
        end
    end

    always @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            phase_reg <= 16'h0000;
            demod_d_reg <= 1'b0;
            bit_reg <= 1'b0;
            sample_reg <= 1'b0;
        end else begin
            demod_d_reg <= DEMOD_IN;
            sample_reg <= 1'b0;
            if (!tick_reg) begin
            end else if (edge_seen) begin
                // (RULE21) Align to transitions
                phase_reg <= 16'h0000;
            end else if (phase_reg >= BAUD_DIV - 16'h0001) begin
                phase_reg <= 16'h0000;
            end else begin
                phase_reg <= phase_reg + 16'h0001;
                if (phase_reg == half_bit) begin
                    bit_reg <= DEMOD_IN;
                    sample_reg <= 1'b1;
                end
            end
        end
    end

    // (RULE11) Two clock periods per bit, rise mid-bit
    wire clk_phase;
    assign clk_phase = (phase_reg >= half_bit) ?
        (phase_reg - half_bit < quarter_bit) :
        (phase_reg < quarter_bit);

    reg retimed_reg;
    wire buf_in_ready;
    wire buf_out_valid;
    wire buf_out_data;

    // Bits arriving while the buffer is full are dropped, not retimed
    rscr_buf2 #(
        .WIDTH(1)
    ) u_buf (
        .clk(MCLK),
        .rst_b(RST_B),
        .in_valid(sample_reg && retime_on),
        .in_ready(buf_in_ready),
        .in_data(bit_reg),
        .out_valid(buf_out_valid),
        .out_ready(HOST_READY),
        .out_data(buf_out_data)
    );
    assign BIT_VALID = buf_out_valid;
    assign BIT_DATA = buf_out_data;

    always @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            retimed_reg <= 1'b0;
            DATA_OUT <= 1'b0;
            CLK_OUT <= 1'b0;
        end else begin
            if (sample_reg && buf_in_ready) begin
                retimed_reg <= bit_reg;
            end
            DATA_OUT <= retime_on ? retimed_reg : DEMOD_IN;
            // (RULE21) Clock low when disabled
            CLK_OUT <= clk_on ? clk_phase : 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### sim/rscr_checker.sv
// Concurrent checks on the configuration and recovery ports
`timescale 1ns/10ps
`default_nettype none
module rscr_checker (
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic REG_WE,
    input wire logic [6:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA,
    input wire logic PROG_MODE,
    input wire logic CLK_OUT,
    input wire logic HOST_READY,
    input wire logic BIT_VALID,
    input wire logic BIT_DATA,
    input wire logic TIMEBASE_TICK,
    input wire logic [23:0] SYNTH_WORD,
    input wire logic [15:0] SYNTH_FRAC,
    input wire logic [1:0] LO_DIVIDER,
    input wire logic FRAC_ENABLE,
    input wire logic INJECT_HIGH,
    input wire logic [1:0] LATENCY_SEL,
    input wire logic LATENCY_RESERVED
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    chk_tick_spacing: assert property (
        TIMEBASE_TICK |=> (!TIMEBASE_TICK)[*3] ##[1:3] TIMEBASE_TICK)
        else $error("time base tick spacing wrong");
    chk_word_high: assert property (
        REG_WE && REG_ADDR == 7'h09 |=> SYNTH_WORD[23:16] == $past(REG_WDATA))
        else $error("synth word high byte not taken");
    chk_frac_mid: assert property (
        REG_WE && REG_ADDR == 7'h0A |=> SYNTH_FRAC[15:8] == $past(REG_WDATA))
        else $error("fractional part not taken");
    chk_afe_fields: assert property (
        REG_WE && REG_ADDR == 7'h19 |=>
        {LO_DIVIDER, INJECT_HIGH, FRAC_ENABLE} == $past(REG_WDATA[5:2]))
        else $error("front end fields wrong");
    chk_lat_code: assert property (
        REG_WE && REG_ADDR == 7'h03 |=> LATENCY_SEL == ($past(REG_WDATA[6]) ?
        ($past(REG_WDATA[7]) ? 2'h2 : 2'h1) : 2'h0) &&
        LATENCY_RESERVED == ($past(REG_WDATA[7:6]) == 2'h2))
        else $error("latency selection wrong");
    chk_clk_gated: assert property (
        !PROG_MODE ##1 !PROG_MODE |-> !CLK_OUT)
        else $error("clock out of programmable mode");
    chk_rd_unmapped: assert property (
        REG_ADDR == 7'h20 |=> REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    chk_buf_hold: assert property (
        BIT_VALID && !HOST_READY |=> BIT_VALID && $stable(BIT_DATA))
        else $error("stalled bit lost or changed");
endmodule
bind rscr_top rscr_checker rscr_checker_inst (.MCLK(MCLK), .RST_B(RST_B),
    .REG_WE(REG_WE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA), .PROG_MODE(PROG_MODE), .CLK_OUT(CLK_OUT),
    .HOST_READY(HOST_READY), .BIT_VALID(BIT_VALID), .BIT_DATA(BIT_DATA),
    .TIMEBASE_TICK(TIMEBASE_TICK), .SYNTH_WORD(SYNTH_WORD),
    .SYNTH_FRAC(SYNTH_FRAC), .LO_DIVIDER(LO_DIVIDER),
    .FRAC_ENABLE(FRAC_ENABLE), .INJECT_HIGH(INJECT_HIGH),
    .LATENCY_SEL(LATENCY_SEL), .LATENCY_RESERVED(LATENCY_RESERVED));
`default_nettype wire

// ### sim/rscr_host_model.sv
// Host model: latches data on the recovered clock, drains the bit buffer
`timescale 1ns/10ps
`default_nettype none
module rscr_host_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic stall,
    input wire logic data_out,
    input wire logic clk_out,
    input wire logic bit_valid,
    input wire logic bit_data,
    output logic host_ready,
    output logic latched,
    output int rises,
    output int pops,
    output int pop_ones
);
    logic clk_out_d;
    assign host_ready = !stall;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            clk_out_d <= 1'b0;
            latched <= 1'b0;
            rises <= 0;
            pops <= 0;
            pop_ones <= 0;
        end else begin
            clk_out_d <= clk_out;
            if (clk_out && !clk_out_d) begin
                latched <= data_out;
                rises <= rises + 1;
            end
            if (bit_valid && host_ready) begin
                pops <= pops + 1;
                pop_ones <= pop_ones + (bit_data ? 1 : 0);
            end
        end
    end
endmodule
`default_nettype wire

// ### sim/testbench.sv
// Self-checking bench for the configuration and recovery block
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic MCLK, RST_B, REG_WE, PROG_MODE, DEMOD_IN, stall;
    logic [6:0] REG_ADDR;
    logic [7:0] REG_WDATA, REG_RDATA;
    logic DATA_OUT, CLK_OUT, HOST_READY, BIT_VALID, BIT_DATA, TICK, FRAC_EN;
    logic INJ, LAT_RES, latched;
    logic [23:0] SYNTH_WORD, word;
    logic [15:0] SYNTH_INT, SYNTH_FRAC;
    logic [1:0] LO_DIV, LAT_SEL;
    logic [31:0] seed;
    logic [6:0] addrs [6] = '{7'h03, 7'h09, 7'h0A, 7'h0B, 7'h19, 7'h35};
    int num_errors = 0, checked = 0, cycles = 0;
    int i, n, r0, p0, o0, rises, pops, pop_ones;
    rscr_top #(.BAUD_DIV(16'h0008)) rscr_top_inst (.MCLK(MCLK),
        .RST_B(RST_B), .REG_WE(REG_WE), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .PROG_MODE(PROG_MODE),
        .DEMOD_IN(DEMOD_IN), .DATA_OUT(DATA_OUT), .CLK_OUT(CLK_OUT),
        .HOST_READY(HOST_READY), .BIT_VALID(BIT_VALID), .BIT_DATA(BIT_DATA),
        .TIMEBASE_TICK(TICK), .SYNTH_WORD(SYNTH_WORD), .SYNTH_INT(SYNTH_INT),
        .SYNTH_FRAC(SYNTH_FRAC), .LO_DIVIDER(LO_DIV), .FRAC_ENABLE(FRAC_EN),
        .INJECT_HIGH(INJ), .LATENCY_SEL(LAT_SEL), .LATENCY_RESERVED(LAT_RES));
    rscr_host_model rscr_host_model_inst (.clk(MCLK), .rst_b(RST_B),
        .stall(stall), .data_out(DATA_OUT), .clk_out(CLK_OUT),
        .bit_valid(BIT_VALID), .bit_data(BIT_DATA), .host_ready(HOST_READY),
        .latched(latched), .rises(rises), .pops(pops), .pop_ones(pop_ones));
    always #12.5 MCLK = ~MCLK;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [1:0] lat_exp(input logic bw, input logic buf_on);
        return bw ? (buf_on ? 2'h2 : 2'h1) : 2'h0;
    endfunction
    function automatic logic [23:0] word_for(input longint mark_khz,
        input longint space_khz, input longint if_khz, input longint xtal_khz);
        return 24'((65536 * (mark_khz + space_khz - 2 * if_khz) + xtal_khz) /
                   (2 * xtal_khz));
    endfunction
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge MCLK);
        #2;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        REG_WE = 1'b1;
        REG_ADDR = a;
        REG_WDATA = d;
        cyc(1);
        REG_WE = 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        REG_ADDR = a;
        cyc(1);
        check(REG_RDATA, exp);
    endtask
    task automatic tick_gap(output int g);
        g = 1;
        while (TICK !== 1'b1) cyc(1);
        cyc(1);
        while (TICK !== 1'b1) begin
            cyc(1);
            g++;
        end
    endtask
    task results;
        if (num_errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge MCLK) begin
        cycles++;
        if (cycles == 10000) begin
            num_errors++;
            results();
        end
    end
    initial begin
        MCLK = 1'b0;
        RST_B = 1'b0;
        REG_WE = 1'b0;
        REG_ADDR = 7'h00;
        REG_WDATA = 8'h00;
        PROG_MODE = 1'b1;
        DEMOD_IN = 1'b0;
        stall = 1'b0;
        seed = 32'h6791FFAC;
        cyc(4);
        RST_B = 1'b1;
        for (i = 0; i < 6; i++)
            rd(addrs[i], addrs[i] == 7'h19 ? 8'h05 : 8'h00);
        for (i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            if (i == 4) seed[3:2] = 2'b01;
            wr(addrs[i], seed[7:0]);
            rd(addrs[i], i == 5 ? {6'h00, seed[1:0]} : seed[7:0]);
            if (i >= 1 && i <= 3)
                word[8 * (3 - i) +: 8] = seed[7:0];
        end
        check(SYNTH_WORD, word);
        check({8'h00, SYNTH_INT}, {16'h0000, word[23:16]});
        word = word_for(433940, 433900, 400, 16000);
        wr(7'h09, word[23:16]);
        wr(7'h0A, word[15:8]);
        wr(7'h0B, word[7:0]);
        check(SYNTH_WORD, 24'h1B1852);
        check({8'h00, SYNTH_FRAC}, {8'h00, word[15:0]});
        wr(7'h20, 8'hFF);
        rd(7'h20, 8'h00);
        for (i = 0; i < 4; i++) begin
            wr(7'h03, {i[1:0], 6'h1A});
            check(LAT_SEL, lat_exp(i[0], i[1]));
            check(LAT_RES, i == 2);
        end
        for (i = 0; i < 4; i++) begin
            wr(7'h19, 8'h14 | i[7:0]);
            tick_gap(n);
            tick_gap(n);
            check(n, i == 3 ? 6 : 4 + i);
        end
        wr(7'h19, 8'h15);
        for (i = 0; i < 40; i++) begin
            wr(7'h35, {7'h00, i[0]});
            seed = lfsr(seed);
            DEMOD_IN = seed[0];
            cyc(1);
            check(DATA_OUT, DEMOD_IN);
            if (!i[0])
                check(CLK_OUT, 1'b0);
        end
        wr(7'h35, 8'h03);
        DEMOD_IN = 1'b1;
        cyc(200);
        r0 = rises;
        cyc(400);
        check(rises - r0 >= 19 && rises - r0 <= 21, 1'b1);
        check(latched, 1'b1);
        DEMOD_IN = 1'b0;
        cyc(200);
        check(latched, 1'b0);
        PROG_MODE = 1'b0;
        cyc(1);
        r0 = rises;
        cyc(200);
        check(rises - r0, 0);
        PROG_MODE = 1'b1;
        wr(7'h03, 8'h00);
        r0 = rises;
        cyc(200);
        check(rises - r0, 0);
        DEMOD_IN = 1'b1;
        wr(7'h03, 8'h1A);
        wr(7'h35, 8'h02);
        stall = 1'b1;
        r0 = rises;
        cyc(300);
        check(BIT_VALID, 1'b1);
        check(rises - r0, 0);
        p0 = pops;
        o0 = pop_ones;
        stall = 1'b0;
        cyc(3);
        check(pops - p0 >= 2 && pops - p0 <= 3, 1'b1);
        check(pop_ones - o0, pops - p0);
        results();
    end
endmodule
`default_nettype wire
